/* logic/ibsc_top.sv */
// Two-wire bus sequence controller: APB registers on clk_sys, bus engine on clk_link
//
// The implementer's own choices: the address map and the APB interface to the registers.
module ibsc_top
	import ibsc_pkg::*;
#(
	parameter int QUARTER = ibsc_pkg::IBSC_QUARTER_DEF
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link clock
	input wire logic clk_link,
	// Bus lines, open drain: output level is always low
	input wire ibsc_pkg::ibsc_pins_type pin_in,
	output ibsc_pkg::ibsc_pins_type pin_out,
	output ibsc_pkg::ibsc_pins_type pin_oe
);
	import ibsc_pkg::*;

	initial
	begin
		if (QUARTER < 2 || QUARTER > 255)
			$error("ibsc_top: QUARTER must lie in 2..255");
	end

	// System domain state
	logic [5:0] ctrl_q, ctrl_d;
	logic role_q, role_d;
	logic busy_q, busy_d;
	logic req_tgl_q, req_tgl_d;
	logic rel_tgl_q, rel_tgl_d;
	logic done_seen_q, done_seen_d;
	ibsc_req_type req_q, req_d;
	ibsc_rsp_type rsp_q, rsp_d;
	logic [31:0] prdata_d;
	logic done_s, acc_wr, setup;

	// Link domain state
	ibsc_state_type state_q, state_d;
	logic [7:0] qcnt_q, qcnt_d;
	logic [1:0] phase_q, phase_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d;
	logic scl_low_q, scl_low_d;
	logic sda_low_q, sda_low_d;
	logic ack_stat_q, ack_stat_d;
	logic done_tgl_q, done_tgl_d;
	logic req_seen_q, req_seen_d;
	logic rel_seen_q, rel_seen_d;
	ibsc_req_type lreq_q, lreq_d;
	logic scl_prev_q, scl_prev_d;
	logic sda_prev_q, sda_prev_d;
	logic tgt_act_q, tgt_act_d;
	logic [3:0] fall_cnt_q, fall_cnt_d;
	logic stretch_q, stretch_d;
	ibsc_pins_type pins_s;
	logic req_s, rel_s, role_s, stretch_en_s;
	logic tick;
	logic [3:0] last_bit;

	// Pins, request and release toggles, and control levels into link domain
	ibsc_sync #(.WIDTH(6)) u_link_sync
	(
		.clk(clk_link),
		.nrst(nrst),
		.d({pin_in.scl, pin_in.sda, req_tgl_q, rel_tgl_q, role_q, ctrl_q[IBSC_BIT_START]}),
		.q({pins_s.scl, pins_s.sda, req_s, rel_s, role_s, stretch_en_s})
	);

	// Completion toggle into system domain
	ibsc_sync #(.WIDTH(1)) u_sys_sync
	(
		.clk(clk_sys),
		.nrst(nrst),
		.d(done_tgl_q),
		.q(done_s)
	);

	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pwrite;

	always_comb
	begin
		ctrl_d = ctrl_q;
		role_d = role_q;
		busy_d = busy_q;
		req_tgl_d = req_tgl_q;
		rel_tgl_d = rel_tgl_q;
		done_seen_d = done_s;
		req_d = req_q;
		rsp_d = rsp_q;
		prdata_d = prdata;
		pslverr = 1'b0;
		if (psel && !(paddr == IBSC_OFF_CTRL || paddr == IBSC_OFF_CFG ||
			paddr == IBSC_OFF_TXB || paddr == IBSC_OFF_RXB))
			pslverr = penable;
		// Completion: launch bits drop, response captured while link holds it
		if (done_s != done_seen_q)
		begin
			busy_d = 1'b0;
			rsp_d = rsp_q;
			rsp_d.rx_byte = shift_q;
			rsp_d.ack_stat = ack_stat_q;
			ctrl_d[IBSC_BIT_ACK:IBSC_BIT_RESTART] = '0;
			if (role_q)
				ctrl_d[IBSC_BIT_START] = 1'b0;
		end
		if (acc_wr && paddr == IBSC_OFF_CTRL)
		begin
			ctrl_d[IBSC_BIT_ACKLVL] = pwdata[IBSC_BIT_ACKLVL];
			if (!role_q)
				ctrl_d[IBSC_BIT_START] = pwdata[IBSC_BIT_START];
			else if (!busy_q && pwdata[IBSC_BIT_ACK:IBSC_BIT_START] != 5'h00)
			begin
				// One launch per write; lowest bit wins when several are written
				busy_d = 1'b1;
				req_tgl_d = !req_tgl_q;
				req_d.ack_level = pwdata[IBSC_BIT_ACKLVL];
				req_d.tx_byte = req_q.tx_byte;
				if (pwdata[IBSC_BIT_START])
				begin
					req_d.op = IBSC_OP_START;
					ctrl_d[IBSC_BIT_START] = 1'b1;
				end
				else if (pwdata[IBSC_BIT_RESTART])
				begin
					req_d.op = IBSC_OP_RESTART;
					ctrl_d[IBSC_BIT_RESTART] = 1'b1;
				end
				else if (pwdata[IBSC_BIT_STOP])
				begin
					req_d.op = IBSC_OP_STOP;
					ctrl_d[IBSC_BIT_STOP] = 1'b1;
				end
				else if (pwdata[IBSC_BIT_RX])
				begin
					req_d.op = IBSC_OP_RX;
					ctrl_d[IBSC_BIT_RX] = 1'b1;
				end
				else
				begin
					req_d.op = IBSC_OP_ACK;
					ctrl_d[IBSC_BIT_ACK] = 1'b1;
				end
			end
		end
		if (acc_wr && paddr == IBSC_OFF_CFG)
		begin
			// Role change only while idle, so no sequence is cut short
			if (!busy_q)
				role_d = pwdata[IBSC_BIT_ROLE];
			if (pwdata[IBSC_BIT_RELEASE])
				rel_tgl_d = !rel_tgl_q;
		end
		if (acc_wr && paddr == IBSC_OFF_TXB && role_q && !busy_q)
		begin
			busy_d = 1'b1;
			req_tgl_d = !req_tgl_q;
			req_d.op = IBSC_OP_TX;
			req_d.ack_level = ctrl_q[IBSC_BIT_ACKLVL];
			req_d.tx_byte = pwdata[7:0];
		end
		// Read data prepared in setup so it is a flop in the access phase
		if (setup)
		begin
			prdata_d = '0;
			case (paddr)
				IBSC_OFF_CTRL: prdata_d[7:0] = {1'b0, rsp_q.ack_stat, ctrl_q};
				IBSC_OFF_CFG: prdata_d[IBSC_BIT_ROLE] = role_q;
				IBSC_OFF_TXB: prdata_d[7:0] = req_q.tx_byte;
				IBSC_OFF_RXB: prdata_d[8:0] = {busy_q, rsp_q.rx_byte};
				default: prdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_q <= IBSC_CTRL_RST;
			role_q <= IBSC_ROLE_RST;
			busy_q <= 1'b0;
			req_tgl_q <= 1'b0;
			rel_tgl_q <= 1'b0;
			done_seen_q <= 1'b0;
			req_q <= '0;
			rsp_q <= '0;
			prdata <= '0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			role_q <= role_d;
			busy_q <= busy_d;
			req_tgl_q <= req_tgl_d;
			rel_tgl_q <= rel_tgl_d;
			done_seen_q <= done_seen_d;
			req_q <= req_d;
			rsp_q <= rsp_d;
			prdata <= prdata_d;
		end
	end

	// Quarter-bit tick; a target holding the clock low freezes the count
	assign tick = (qcnt_q == 8'(QUARTER - 1));

	always_comb
	begin
		case (state_q)
			IBSC_ST_TX: last_bit = IBSC_TX_LAST;
			IBSC_ST_RX: last_bit = IBSC_RX_LAST;
			default: last_bit = IBSC_ACK_LAST;
		endcase
	end

	always_comb
	begin
		state_d = state_q;
		qcnt_d = qcnt_q;
		phase_d = phase_q;
		bit_d = bit_q;
		shift_d = shift_q;
		scl_low_d = scl_low_q;
		sda_low_d = sda_low_q;
		ack_stat_d = ack_stat_q;
		done_tgl_d = done_tgl_q;
		req_seen_d = req_seen_q;
		rel_seen_d = rel_s;
		lreq_d = lreq_q;
		scl_prev_d = pins_s.scl;
		sda_prev_d = pins_s.sda;
		tgt_act_d = tgt_act_q;
		fall_cnt_d = fall_cnt_q;
		stretch_d = stretch_q;
		if (state_q != IBSC_ST_IDLE && !(scl_low_q == 1'b0 && !pins_s.scl))
			qcnt_d = tick ? 8'h00 : qcnt_q + 8'h01;
		case (state_q)
			IBSC_ST_IDLE:
			begin
				if (req_s != req_seen_q)
				begin
					req_seen_d = req_s;
					lreq_d = req_q;
					qcnt_d = 8'h00;
					phase_d = 2'h0;
					bit_d = 4'h0;
					case (req_q.op)
						IBSC_OP_START: state_d = IBSC_ST_START;
						IBSC_OP_RESTART: state_d = IBSC_ST_RESTART;
						IBSC_OP_STOP: state_d = IBSC_ST_STOP;
						IBSC_OP_RX: state_d = IBSC_ST_RX;
						IBSC_OP_ACK: state_d = IBSC_ST_ACK;
						IBSC_OP_TX:
						begin
							state_d = IBSC_ST_TX;
							shift_d = req_q.tx_byte;
						end
						default: state_d = IBSC_ST_IDLE;
					endcase
				end
			end
			IBSC_ST_START:
			begin
				if (tick)
				begin
					phase_d = phase_q + 2'h1;
					case (phase_q)
						2'h0:
						begin
							scl_low_d = 1'b0;
							sda_low_d = 1'b0;
						end
						2'h1: sda_low_d = 1'b1;
						default:
						begin
							scl_low_d = 1'b1;
							state_d = IBSC_ST_IDLE;
							done_tgl_d = !done_tgl_q;
						end
					endcase
				end
			end
			IBSC_ST_RESTART:
			begin
				if (tick)
				begin
					phase_d = phase_q + 2'h1;
					case (phase_q)
						2'h0: sda_low_d = 1'b0;
						2'h1: scl_low_d = 1'b0;
						2'h2: sda_low_d = 1'b1;
						default:
						begin
							scl_low_d = 1'b1;
							state_d = IBSC_ST_IDLE;
							done_tgl_d = !done_tgl_q;
						end
					endcase
				end
			end
			IBSC_ST_STOP:
			begin
				if (tick)
				begin
					phase_d = phase_q + 2'h1;
					case (phase_q)
						2'h0: sda_low_d = 1'b1;
						2'h1: scl_low_d = 1'b0;
						default:
						begin
							sda_low_d = 1'b0;
							state_d = IBSC_ST_IDLE;
							done_tgl_d = !done_tgl_q;
						end
					endcase
				end
			end
			IBSC_ST_TX, IBSC_ST_RX, IBSC_ST_ACK:
			begin
				if (tick)
				begin
					phase_d = phase_q + 2'h1;
					case (phase_q)
						2'h0:
						begin
							if (state_q == IBSC_ST_TX)
								sda_low_d = (bit_q != IBSC_TX_LAST) && !shift_q[7];
							else if (state_q == IBSC_ST_ACK)
								sda_low_d = !lreq_q.ack_level;
							else
								sda_low_d = 1'b0;
						end
						2'h1: scl_low_d = 1'b0;
						2'h2:
						begin
							if (state_q == IBSC_ST_TX && bit_q == IBSC_TX_LAST)
								ack_stat_d = pins_s.sda;
							else if (state_q == IBSC_ST_TX)
								shift_d = {shift_q[6:0], 1'b0};
							else if (state_q == IBSC_ST_RX)
								shift_d = {shift_q[6:0], pins_s.sda};
						end
						default:
						begin
							scl_low_d = 1'b1;
							bit_d = bit_q + 4'h1;
							if (bit_q == last_bit)
							begin
								// Data line left released so the next phase starts clean
								sda_low_d = 1'b0;
								state_d = IBSC_ST_IDLE;
								done_tgl_d = !done_tgl_q;
							end
						end
					endcase
				end
			end
			default: state_d = IBSC_ST_IDLE;
		endcase
		// Target role: hold the clock low after each byte and its acknowledge
		if (role_s)
			tgt_act_d = 1'b0;
		else if (sda_prev_q && !pins_s.sda && pins_s.scl)
		begin
			tgt_act_d = 1'b1;
			fall_cnt_d = 4'h0;
		end
		else if (!sda_prev_q && pins_s.sda && pins_s.scl)
			tgt_act_d = 1'b0;
		else if (tgt_act_q && scl_prev_q && !pins_s.scl)
		begin
			fall_cnt_d = fall_cnt_q + 4'h1;
			if (fall_cnt_q == IBSC_TGT_CLOCKS)
			begin
				fall_cnt_d = 4'h1;
				stretch_d = stretch_en_s;
			end
		end
		if (rel_s != rel_seen_q || role_s || !stretch_en_s)
			stretch_d = 1'b0;
	end

	always_ff @(posedge clk_link or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= IBSC_ST_IDLE;
			qcnt_q <= 8'h00;
			phase_q <= 2'h0;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			ack_stat_q <= 1'b0;
			done_tgl_q <= 1'b0;
			req_seen_q <= 1'b0;
			rel_seen_q <= 1'b0;
			lreq_q <= '0;
			scl_prev_q <= 1'b0;
			sda_prev_q <= 1'b0;
			tgt_act_q <= 1'b0;
			fall_cnt_q <= 4'h0;
			stretch_q <= 1'b0;
			pin_oe <= '0;
		end
		else
		begin
			state_q <= state_d;
			qcnt_q <= qcnt_d;
			phase_q <= phase_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			scl_low_q <= scl_low_d;
			sda_low_q <= sda_low_d;
			ack_stat_q <= ack_stat_d;
			done_tgl_q <= done_tgl_d;
			req_seen_q <= req_seen_d;
			rel_seen_q <= rel_seen_d;
			lreq_q <= lreq_d;
			scl_prev_q <= scl_prev_d;
			sda_prev_q <= sda_prev_d;
			tgt_act_q <= tgt_act_d;
			fall_cnt_q <= fall_cnt_d;
			stretch_q <= stretch_d;
			pin_oe.scl <= scl_low_d || stretch_d;
			pin_oe.sda <= sda_low_d;
		end
	end

	assign pin_out = '0;
endmodule

/* logic/ibsc_pkg.sv */
// Shared constants and types for the two-wire bus sequence controller
package ibsc_pkg;

	// Register byte offsets
	localparam logic [7:0] IBSC_OFF_CTRL = 8'h00;
	localparam logic [7:0] IBSC_OFF_CFG = 8'h04;
	localparam logic [7:0] IBSC_OFF_TXB = 8'h08;
	localparam logic [7:0] IBSC_OFF_RXB = 8'h0C;

	// bus_sequence_control fields
	localparam int IBSC_BIT_START = 0;
	localparam int IBSC_BIT_RESTART = 1;
	localparam int IBSC_BIT_STOP = 2;
	localparam int IBSC_BIT_RX = 3;
	localparam int IBSC_BIT_ACK = 4;
	localparam int IBSC_BIT_ACKLVL = 5;
	localparam int IBSC_BIT_ACKSTAT = 6;

	// Configuration fields and receive register flag
	localparam int IBSC_BIT_ROLE = 0;
	localparam int IBSC_BIT_RELEASE = 1;
	localparam int IBSC_BIT_BUSY = 8;

	// Reset values
	localparam logic [5:0] IBSC_CTRL_RST = 6'h00;
	localparam logic IBSC_ROLE_RST = 1'b1;

	// Bus timing: link cycles per quarter bit, and target byte plus acknowledge length in clocks
	localparam int IBSC_QUARTER_DEF = 5;
	localparam logic [3:0] IBSC_TGT_CLOCKS = 4'h9;
	localparam logic [3:0] IBSC_TX_LAST = 4'h8;
	localparam logic [3:0] IBSC_RX_LAST = 4'h7;
	localparam logic [3:0] IBSC_ACK_LAST = 4'h0;

	typedef enum logic [2:0]
	{
		IBSC_OP_START = 3'h0,
		IBSC_OP_RESTART = 3'h1,
		IBSC_OP_STOP = 3'h2,
		IBSC_OP_RX = 3'h3,
		IBSC_OP_ACK = 3'h4,
		IBSC_OP_TX = 3'h5
	} ibsc_op_type;

	typedef enum logic [6:0]
	{
		IBSC_ST_IDLE = 7'b0000001,
		IBSC_ST_START = 7'b0000010,
		IBSC_ST_RESTART = 7'b0000100,
		IBSC_ST_STOP = 7'b0001000,
		IBSC_ST_TX = 7'b0010000,
		IBSC_ST_RX = 7'b0100000,
		IBSC_ST_ACK = 7'b1000000
	} ibsc_state_type;

	typedef struct packed
	{
		ibsc_op_type op;
		logic ack_level;
		logic [7:0] tx_byte;
	} ibsc_req_type;

	typedef struct packed
	{
		logic [7:0] rx_byte;
		logic ack_stat;
	} ibsc_rsp_type;

	typedef struct packed
	{
		logic scl;
		logic sda;
	} ibsc_pins_type;

endpackage

/* logic/ibsc_sync.sv */
// Two-flop synchroniser for levels and toggles entering a clock domain
module ibsc_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Asynchronous in, synchronised out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	initial
	begin
		if (WIDTH < 1)
			$error("ibsc_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

/* verification/ibsc_monitor.sv */
// Port checker for the bus sequence controller, bound into the top
module ibsc_monitor
	import ibsc_pkg::*;
#(
	parameter int QUARTER = 5
) (
	// System side
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Link side
	input wire logic clk_link,
	input wire ibsc_pkg::ibsc_pins_type pin_out,
	input wire ibsc_pkg::ibsc_pins_type pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc;
	logic rd;
	logic map;
	logic lvl_q;
	logic lvl_d;
	logic [7:0] low_q;
	logic [7:0] low_d;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign map = paddr inside {IBSC_OFF_CTRL, IBSC_OFF_CFG, IBSC_OFF_TXB, IBSC_OFF_RXB};
	always_comb
	begin
		lvl_d = lvl_q;
		if (acc && pwrite && paddr == IBSC_OFF_CTRL)
			lvl_d = pwdata[IBSC_BIT_ACKLVL];
	end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			lvl_q <= 1'b0;
		else
			lvl_q <= lvl_d;
	end
	// Saturating run length of the clock line held low
	always_comb
		low_d = pin_oe.scl ? low_q + {7'h0, low_q != 8'hFF} : 8'h00;
	always_ff @(posedge clk_link or negedge nrst)
	begin
		if (!nrst)
			low_q <= 8'h00;
		else
			low_q <= low_d;
	end
	unmapped_refuse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		acc && !map |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
	slverr_cause_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		pslverr |-> acc && !map) else $error("stray pslverr");
	ready_prompt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		psel && !penable |=> pready) else $error("pready late");
	ctrl_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		rd && paddr == IBSC_OFF_CTRL |-> prdata[31:7] == 25'h0 && prdata[IBSC_BIT_ACKLVL] == lvl_q)
		else $error("control read wrong");
	cfg_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		rd && paddr == IBSC_OFF_CFG |-> prdata[31:1] == 31'h0) else $error("config read wrong");
	rx_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		rd && paddr == IBSC_OFF_RXB |-> prdata[31:9] == 23'h0) else $error("receive read wrong");
	rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!psel |=> $stable(prdata)) else $error("prdata moved while idle");
	open_drain_a: assert property (@(posedge clk_link) disable iff (!nrst)
		pin_out == 2'h0) else $error("line driven high");
	lines_free_a: assert property (@(posedge clk_link) disable iff (!nrst)
		!$past(nrst) |-> pin_oe == 2'h0) else $error("lines held after reset");
	scl_low_time_a: assert property (@(posedge clk_link) disable iff (!nrst)
		$fell(pin_oe.scl) |-> low_q >= 8'(2 * QUARTER)) else $error("clock low too short");
endmodule
bind ibsc_top ibsc_monitor #(.QUARTER(QUARTER)) ibsc_monitor_i (.clk_sys, .nrst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .clk_link, .pin_out, .pin_oe);

/* verification/ibsc_target_model.sv */
// Behavioural bus target: acknowledges writes, serves reads, may stretch
module ibsc_target_model (
	// Resolved lines
	input wire logic scl,
	input wire logic sda,
	// Behaviour
	input wire logic [7:0] tx,
	input wire logic slow,
	// Pulls and observations
	output logic sda_oe,
	output logic scl_oe,
	output logic [7:0] got,
	output logic got_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = -1;
	logic rd = 0;
	logic first = 0;
	logic [7:0] sh = 8'h00;
	initial
	begin
		sda_oe = 0;
		scl_oe = 0;
	end
	always @(negedge sda)
		if (scl)
		begin
			n = 0;
			first = 1;
			rd = 0;
		end
	always @(posedge sda)
		if (scl)
			n = -1;
	always @(posedge scl)
		if (n >= 0)
		begin
			if (n < 8)
				sh = {sh[6:0], sda};
			else
				got_ack = sda;
			n++;
		end
	// Data only changes while the clock is low
	always @(negedge scl)
		if (n == 8)
		begin
			got = sh;
			if (first)
				rd = sh[0];
			sda_oe = first || !rd;
			first = 0;
		end
		else if (n == 9)
		begin
			n = 0;
			rd = rd && !got_ack;
			sda_oe = rd && !tx[7];
			if (slow)
			begin
				scl_oe = 1;
				// Long enough to overlap the next release of the clock line
				#1500 scl_oe = 0;
			end
		end
		else if (n > 0)
			sda_oe = rd && !tx[7 - n];
endmodule

/* verification/ibsc_top_tb.sv */
// Bench for the bus sequence controller: APB traffic against a bus target model
module ibsc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ibsc_pkg::*;
	typedef struct packed {logic [31:0] d; logic [31:0] m;} ibsc_exp_type;
	logic clk_sys = 0, clk_link = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 0, tx = 8'hFF, got, a, d;
	logic [31:0] pwdata = 0, prdata, r;
	logic m_sda, m_scl, tb_sda = 0, tb_scl = 0, slow = 0, got_ack;
	wire ibsc_pins_type pin_in;
	ibsc_pins_type pin_out, pin_oe;
	int n_errors = 0, checked = 0;
	ibsc_exp_type q[$];
	ibsc_exp_type e;
	assign pin_in = {!(pin_oe.scl || m_scl || tb_scl), !(pin_oe.sda || m_sda || tb_sda)};
	initial forever #12.5 clk_sys = !clk_sys;
	initial
	begin
		#7;
		forever #24 clk_link = !clk_link;
	end
	ibsc_top #(.QUARTER(2)) ibsc_top_i (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .clk_link, .pin_in, .pin_out, .pin_oe);
	ibsc_target_model ibsc_target_model_i (.scl(pin_in.scl), .sda(pin_in.sda), .tx, .slow, .sda_oe(m_sda),
		.scl_oe(m_scl), .got, .got_ack);
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt, input logic [31:0] m = 0);
		@(posedge clk_sys);
		if (!w)
			q.push_back('{dt, m});
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge clk_sys);
		penable <= 1;
		do
			@(posedge clk_sys);
		while (pready !== 1);
		r = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	// Busy rises at the write; the sequence itself needs link cycles, so poll until it drops
	task automatic op(input logic [7:0] ad, input logic [7:0] dt);
		apb(1, ad, {24'h0, dt});
		repeat (12) @(posedge clk_sys);
		r = 32'h100;
		while (r[IBSC_BIT_BUSY] !== 0)
			apb(0, IBSC_OFF_RXB, 0);
	endtask
	task automatic pause();
		repeat (8) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys)
		if (psel && penable && !pwrite && pready === 1 && q.size() > 0)
		begin
			e = q.pop_front();
			if (e.m !== 0)
				chk("prdata", e.d & e.m, prdata & e.m);
		end
	initial
	begin
		#300us;
		n_errors++;
		summarize();
	end
	initial
	begin
		r = $urandom(32'h40BEED06);
		repeat (20) @(posedge clk_sys);
		nrst <= 1;
		apb(0, IBSC_OFF_CTRL, 0, '1);
		apb(0, IBSC_OFF_CFG, 1, '1);
		apb(0, 8'($urandom_range(4, 63) * 4), 0, '1);
		op(IBSC_OFF_CTRL, 8'h01);
		apb(0, IBSC_OFF_CTRL, 0, 32'h1F);
		a = 8'($urandom) & 8'hFE;
		op(IBSC_OFF_TXB, a);
		chk("addr", a, got);
		apb(0, IBSC_OFF_CTRL, 0, 32'h40);
		d = 8'($urandom);
		apb(1, IBSC_OFF_TXB, d);
		repeat (12) @(posedge clk_sys);
		apb(1, IBSC_OFF_CTRL, 1);
		apb(0, IBSC_OFF_CTRL, 0, 32'h1);
		op(IBSC_OFF_TXB, ~d);
		chk("byte", d, got);
		apb(0, IBSC_OFF_TXB, d, 32'hFF);
		op(IBSC_OFF_CTRL, 8'h02);
		apb(0, IBSC_OFF_CTRL, 0, 32'h1F);
		tx = 8'($urandom);
		op(IBSC_OFF_TXB, a | 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			slow <= i[0];
			op(IBSC_OFF_CTRL, 8'h08);
			apb(0, IBSC_OFF_RXB, {24'h0, tx}, 32'hFF);
			tx = 8'($urandom);
			op(IBSC_OFF_CTRL, 8'h10 | 8'(i * 32));
			chk("ack", i, got_ack);
			apb(0, IBSC_OFF_CTRL, 0, 32'h1F);
		end
		op(IBSC_OFF_CTRL, 8'h24);
		apb(0, IBSC_OFF_CTRL, 32'h20, 32'h3F);
		chk("lines", 32'h3, pin_in);
		tx = 8'hFF;
		// The partner must not stretch while the bench plays the far side
		slow <= 0;
		for (int i = 1; i >= 0; i--)
		begin
			apb(1, IBSC_OFF_CFG, 0);
			apb(1, IBSC_OFF_CTRL, i);
			apb(0, IBSC_OFF_CTRL, i, 32'h1);
			tb_sda <= 1;
			repeat (10)
			begin
				pause();
				tb_scl <= 1;
				pause();
				tb_scl <= 0;
			end
			pause();
			chk("stretch", i, pin_oe.scl);
			apb(1, IBSC_OFF_CFG, 2);
			repeat (2) pause();
			chk("release", 1, pin_in.scl);
			tb_sda <= 0;
			apb(1, IBSC_OFF_CFG, 1);
		end
		summarize();
	end
endmodule
